//--- src/acss_pkg.sv
// Behaviour
// - In automatic mode every digital input is watched all the time.
// - A valid input moves the sample clock onto it and is shown as reference.
// - Losing the external reference with no other valid input returns the clock to internal master.
// - Each input reports absent, locked, or locked and synchronous.
// - The preferred source is the reference while it carries a valid signal.
// - Without the preferred one, the others are scanned in turn for a valid one.
// - With no valid input at all the clock runs from the internal crystal.
// - A fixed internal mode ignores all inputs and acts as master.
// - Double rate splits the optical port two ways, four channels per port.
// - Quad rate splits the optical port four ways, two channels per port.
// - Single-speed word clock takes a base-rate clock at double or quad rate.
`default_nettype none
package acss_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  // Control fields
  localparam int CTRL_FIXED_BIT = 0;
  localparam int CTRL_PREF_LSB = 1;
  localparam int CTRL_RATE_LSB = 4;
  localparam int CTRL_SINGLE_BIT = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Status fields
  localparam int STAT_REF_LSB = 8;
  localparam int STAT_MASTER_BIT = 11;
  // Interrupt events
  localparam int NUM_EVT = 3;
  localparam int EVT_REF_CHG = 0;
  localparam int EVT_REF_LOST = 1;
  localparam int EVT_LOCK_CHG = 2;
  // Source codes; inputs 0..3 are word, spdif, aes, optical
  localparam int NUM_SRC = 4;
  localparam logic [2:0] SRC_INTERNAL = 3'h0;
  localparam logic [2:0] SRC_WORD = 3'h1;
  // Input states
  localparam logic [1:0] ST_ABSENT = 2'h0;
  localparam logic [1:0] ST_LOCK = 2'h1;
  localparam logic [1:0] ST_SYNC = 2'h2;
  // Rate ranges and optical split
  localparam logic [1:0] RATE_SINGLE = 2'h0;
  localparam logic [1:0] RATE_DOUBLE = 2'h1;
  localparam logic [1:0] SPLIT_NONE = 2'h0;
  localparam logic [1:0] SPLIT_TWO = 2'h1;
  localparam logic [1:0] SPLIT_FOUR = 2'h2;
  localparam logic [3:0] CH_SINGLE = 4'h8;
  localparam logic [3:0] CH_DOUBLE = 4'h4;
  localparam logic [3:0] CH_QUAD = 4'h2;
  // Measurement window in local frame ticks, tolerance, hysteresis windows
  localparam int WIN_TICKS = 64;
  localparam int SYNC_TOL = 1;
  localparam int HYST_WIN = 2;
  // Selection state machine
  typedef enum logic [1:0] {
    ACSS_MASTER = 2'b00,
    ACSS_FOLLOW = 2'b01
  } acss_mode_t;
endpackage : acss_pkg
`default_nettype wire

//--- src/acss_top.sv
// Implementation choices: the address map and the AXI4-Lite register port.
`default_nettype none
// Per-input lock and sync monitor
module acss_mon #(
  parameter int WIN = 64,
  parameter int TOL = 1,
  parameter int HYST = 2
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic rx_tick,
  input wire logic win_end,
  input wire logic [1:0] shift,
  output logic [1:0] state
);
  import acss_pkg::*;
  logic [7:0] cnt_r;
  logic [1:0] hcnt_r;
  logic lock_r;
  logic [1:0] state_r;
  wire [9:0] scaled = {2'h0, cnt_r} << shift;
  wire [9:0] lo = 10'(WIN - TOL);
  wire [9:0] hi = 10'(WIN + TOL);
  wire rate_ok = (scaled >= lo) && (scaled <= hi);
  wire [1:0] hcnt_nxt = (rx_valid != lock_r) ? hcnt_r + 2'h1 : 2'h0;
  wire flip = (rx_valid != lock_r) && (hcnt_r == 2'(HYST - 1));
  assign state = state_r;
  // Frame counting restarts every window; saturates on fast inputs
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 8'h00;
    end else if (win_end) begin
      cnt_r <= {7'h00, rx_tick};
    end else if (rx_tick && cnt_r != 8'hFF) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
  // windowed hysteresis
  // Lock follows the receiver only after HYST disagreeing windows
  always_ff @(posedge clk) begin
    if (rst) begin
      hcnt_r <= 2'h0;
      lock_r <= 1'b0;
      state_r <= ST_ABSENT;
    end else if (win_end) begin
      hcnt_r <= flip ? 2'h0 : hcnt_nxt;
      lock_r <= flip ? rx_valid : lock_r;
      if (!(flip ? rx_valid : lock_r)) begin
        state_r <= ST_ABSENT;
      end else begin
        state_r <= rate_ok ? ST_SYNC : ST_LOCK;
      end
    end
  end
endmodule : acss_mon

module acss_top #(
  parameter int WIN_TICKS_P = acss_pkg::WIN_TICKS,
  parameter int HYST_P = acss_pkg::HYST_WIN
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RESET_IN,
  // Recovered inputs: word, spdif, aes, optical
  input wire logic [3:0] RX_VALID_IN,
  input wire logic [3:0] RX_FRAME_TICK_IN,
  input wire logic LOCAL_FRAME_TICK_IN,
  // Clock selection results
  output logic [2:0] CLK_REF_OUT,
  output logic CLOCK_MASTER_OUT,
  output logic [7:0] INPUT_STATE_OUT,
  output logic [1:0] OPT_SPLIT_OUT,
  output logic [3:0] OPT_CHANNELS_OUT,
  output logic IRQ_OUT,
  // AXI4-Lite write
  input wire logic [7:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  // AXI4-Lite read
  input wire logic [7:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);
  import acss_pkg::*;
  if (WIN_TICKS_P < 4 || WIN_TICKS_P > 200 || HYST_P < 1 || HYST_P > 4) begin
    $error("acss_top: window or hysteresis out of range");
  end
  logic [31:0] ctrl_r;
  logic [2:0] ref_r;
  logic master_r;
  logic [7:0] st_prev_r;
  logic [NUM_EVT-1:0] irq_st_r, irq_en_r;
  logic irq_r;
  logic [1:0] split_r;
  logic [3:0] chans_r;
  logic [7:0] win_r;
  logic win_end_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic aw_hold_r, w_hold_r, awrdy_r, wrdy_r, bvalid_r, bresp_err_r;
  logic arrdy_r, rvalid_r, rresp_err_r;
  logic [31:0] rdata_r;
  wire [7:0] st;

  // Control decode
  wire fixed_int = ctrl_r[CTRL_FIXED_BIT];
  wire [2:0] pref = ctrl_r[CTRL_PREF_LSB +: 3];
  wire [1:0] rate = ctrl_r[CTRL_RATE_LSB +: 2];
  wire single_wck = ctrl_r[CTRL_SINGLE_BIT];
  wire [1:0] rate_shift = (rate == RATE_SINGLE) ? 2'h0 :
                          (rate == RATE_DOUBLE) ? 2'h1 : 2'h2;

  // Window timing from the local sample clock
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      win_r <= 8'h00;
      win_end_r <= 1'b0;
    end else begin
      win_end_r <= LOCAL_FRAME_TICK_IN && win_r == 8'(WIN_TICKS_P - 1);
      if (LOCAL_FRAME_TICK_IN) begin
        win_r <= (win_r == 8'(WIN_TICKS_P - 1)) ? 8'h00 : win_r + 8'h01;
      end
    end
  end

  for (genvar i = 0; i < NUM_SRC; i++) begin : g_mon
    wire [1:0] sh = (i == 0 && single_wck) ? rate_shift : 2'h0;
    acss_mon #(.WIN(WIN_TICKS_P), .TOL(SYNC_TOL), .HYST(HYST_P)) u_mon (
      .clk(CLOCK_IN),
      .rst(RESET_IN),
      .rx_valid(RX_VALID_IN[i]),
      .rx_tick(RX_FRAME_TICK_IN[i]),
      .win_end(win_end_r),
      .shift(sh),
      .state(st[2*i +: 2])
    );
  end

  // scan from preferred onward, first valid wins
  function automatic logic [2:0] pick(input logic [2:0] p,
                                      input logic [7:0] s);
    logic [2:0] res;
    logic [1:0] idx;
    res = SRC_INTERNAL;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      idx = 2'(p - 3'h1) + 2'(k);
      if (s[2*idx +: 2] != ST_ABSENT) begin
        res = 3'(idx) + SRC_WORD;
      end
    end
    return res;
  endfunction : pick

  // fixed internal, preferred first, none valid
  wire [2:0] sel = (fixed_int || pref == SRC_INTERNAL || pref > 3'h4) ?
                   SRC_INTERNAL : pick(pref, st);
  wire acss_mode_t mode_nxt = (sel == SRC_INTERNAL) ? ACSS_MASTER :
                               ACSS_FOLLOW;

  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      ref_r <= SRC_INTERNAL;
      master_r <= 1'b1;
    end else begin
      ref_r <= sel;
      case (mode_nxt)
        ACSS_MASTER: master_r <= 1'b1;
        ACSS_FOLLOW: master_r <= 1'b0;
        default: master_r <= 1'b1;
      endcase
    end
  end

  // optical lane split by rate range
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      split_r <= SPLIT_NONE;
      chans_r <= CH_SINGLE;
    end else begin
      case (rate_shift)
        2'h0: begin
          split_r <= SPLIT_NONE;
          chans_r <= CH_SINGLE;
        end
        2'h1: begin
          split_r <= SPLIT_TWO;
          chans_r <= CH_DOUBLE;
        end
        default: begin
          split_r <= SPLIT_FOUR;
          chans_r <= CH_QUAD;
        end
      endcase
    end
  end

  // Interrupt events; a set beats a clear in the same cycle
  wire [NUM_EVT-1:0] evt;
  assign evt[EVT_REF_CHG] = sel != ref_r;
  assign evt[EVT_REF_LOST] = sel == SRC_INTERNAL && ref_r != SRC_INTERNAL;
  assign evt[EVT_LOCK_CHG] = st != st_prev_r;

  // AXI handshake decode
  wire aw_take = S_AXI_AWVALID_IN && awrdy_r;
  wire w_take = S_AXI_WVALID_IN && wrdy_r;
  wire wr_do = aw_hold_r && w_hold_r && !bvalid_r;
  wire ar_take = S_AXI_ARVALID_IN && arrdy_r;
  wire aw_hold_nxt = !wr_do && (aw_hold_r || aw_take);
  wire w_hold_nxt = !wr_do && (w_hold_r || w_take);
  wire bvalid_nxt = wr_do || (bvalid_r && !S_AXI_BREADY_IN);
  wire rvalid_nxt = ar_take || (rvalid_r && !S_AXI_RREADY_IN);
  wire wr_ctrl = wr_do && aw_addr_r == OFS_CTRL;
  wire wr_en = wr_do && aw_addr_r == OFS_IRQ_EN;
  wire wr_clr = wr_do && aw_addr_r == OFS_IRQ_CLR;
  wire wr_ok = wr_ctrl || wr_en || wr_clr;
  wire [31:0] strb_mask = {{8{S_AXI_WSTRB_IN[3]}}, {8{S_AXI_WSTRB_IN[2]}},
                           {8{S_AXI_WSTRB_IN[1]}}, {8{S_AXI_WSTRB_IN[0]}}};
  wire [NUM_EVT-1:0] clr = wr_clr ? w_data_r[NUM_EVT-1:0] : '0;
  wire [NUM_EVT-1:0] irq_st_nxt = (irq_st_r & ~clr) | evt;
  wire [31:0] stat_word = {20'h0_0000, master_r, ref_r, st};
  wire rd_ok = S_AXI_ARADDR_IN == OFS_CTRL || S_AXI_ARADDR_IN == OFS_STATUS ||
               S_AXI_ARADDR_IN == OFS_IRQ_STAT || S_AXI_ARADDR_IN == OFS_IRQ_EN;
  wire [31:0] rd_mux =
    (S_AXI_ARADDR_IN == OFS_CTRL) ? ctrl_r :
    (S_AXI_ARADDR_IN == OFS_STATUS) ? stat_word :
    (S_AXI_ARADDR_IN == OFS_IRQ_STAT) ? 32'(irq_st_r) :
    (S_AXI_ARADDR_IN == OFS_IRQ_EN) ? 32'(irq_en_r) : 32'h0000_0000;

  // Bus slave; write strobes apply to the held data word
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awrdy_r <= 1'b1;
      wrdy_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_err_r <= 1'b0;
      arrdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_err_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awrdy_r <= !aw_hold_nxt;
      wrdy_r <= !w_hold_nxt;
      bvalid_r <= bvalid_nxt;
      arrdy_r <= !rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (aw_take) aw_addr_r <= S_AXI_AWADDR_IN;
      if (w_take) w_data_r <= S_AXI_WDATA_IN & strb_mask;
      if (wr_do) bresp_err_r <= !wr_ok;
      if (ar_take) begin
        rdata_r <= rd_mux;
        rresp_err_r <= !rd_ok;
      end
    end
  end

  // Control and interrupt registers
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      ctrl_r <= CTRL_RESET;
      irq_st_r <= '0;
      irq_en_r <= '0;
      irq_r <= 1'b0;
      st_prev_r <= 8'h00;
    end else begin
      if (wr_ctrl) ctrl_r <= w_data_r;
      if (wr_en) irq_en_r <= w_data_r[NUM_EVT-1:0];
      irq_st_r <= irq_st_nxt;
      irq_r <= |(irq_st_nxt & (wr_en ? w_data_r[NUM_EVT-1:0] : irq_en_r));
      st_prev_r <= st;
    end
  end

  assign CLK_REF_OUT = ref_r;
  assign CLOCK_MASTER_OUT = master_r;
  assign INPUT_STATE_OUT = st;
  assign OPT_SPLIT_OUT = split_r;
  assign OPT_CHANNELS_OUT = chans_r;
  assign IRQ_OUT = irq_r;
  assign S_AXI_AWREADY_OUT = awrdy_r;
  assign S_AXI_WREADY_OUT = wrdy_r;
  assign S_AXI_BVALID_OUT = bvalid_r;
  assign S_AXI_BRESP_OUT = bresp_err_r ? 2'h2 : 2'h0;
  assign S_AXI_ARREADY_OUT = arrdy_r;
  assign S_AXI_RVALID_OUT = rvalid_r;
  assign S_AXI_RDATA_OUT = rdata_r;
  assign S_AXI_RRESP_OUT = rresp_err_r ? 2'h2 : 2'h0;

  // Checks on selection, input state and optical split behaviour
  property p_fixed;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    fixed_int |=> master_r && ref_r == SRC_INTERNAL;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed mode not master");
  property p_pref;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    (!fixed_int && pref >= SRC_WORD && pref <= 3'h4 &&
     st[2*(pref-3'h1) +: 2] != ST_ABSENT) |=> ref_r == $past(pref);
  endproperty
  a_pref: assert property (p_pref) else $error("preferred not used");
  property p_lost;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    (st == 8'h00) |=> master_r && ref_r == SRC_INTERNAL;
  endproperty
  a_lost: assert property (p_lost) else $error("no input, not master");
  property p_drop;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    (ref_r != SRC_INTERNAL && st == 8'h00) |=>
      master_r && ref_r == SRC_INTERNAL;
  endproperty
  a_drop: assert property (p_drop) else $error("lost ref not master");
  property p_valid_ref;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    ref_r != SRC_INTERNAL |-> st_prev_r[2*(ref_r-3'h1) +: 2] != ST_ABSENT;
  endproperty
  a_valid_ref: assert property (p_valid_ref) else $error("bad ref");
  property p_scan;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    (!fixed_int && pref != SRC_INTERNAL && pref <= 3'h4 && st != 8'h00)
      |=> !master_r;
  endproperty
  a_scan: assert property (p_scan) else $error("valid input unused");
  property p_state;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    st[1:0] != 2'h3 && st[3:2] != 2'h3 && st[5:4] != 2'h3 && st[7:6] != 2'h3;
  endproperty
  a_state: assert property (p_state) else $error("bad input state");
  property p_hyst;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    $changed(st) |-> $past(win_end_r);
  endproperty
  a_hyst: assert property (p_hyst) else $error("state moved off window");
  property p_dbl;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    rate == RATE_DOUBLE |=> split_r == SPLIT_TWO && chans_r == CH_DOUBLE;
  endproperty
  a_dbl: assert property (p_dbl) else $error("double split wrong");
  property p_quad;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
    rate[1] |=> split_r == SPLIT_FOUR && chans_r == CH_QUAD;
  endproperty
  a_quad: assert property (p_quad) else $error("quad split wrong");
  c_follow: cover property (@(posedge CLOCK_IN) $fell(master_r));
  c_fallback: cover property (@(posedge CLOCK_IN) $rose(master_r));
  c_sync: cover property (@(posedge CLOCK_IN) st[1:0] == ST_SYNC);
  c_irq: cover property (@(posedge CLOCK_IN) $rose(irq_r));
endmodule : acss_top
`default_nettype wire

//--- sim/acss_src_model.sv
`default_nettype none
// Far-side digital sources and the local frame clock
module acss_src_model (
  // Clock
  input wire logic clk,
  // Source control from the bench
  input wire logic [3:0] en_in,
  input wire logic [15:0] per_in,
  // Receiver side
  output logic [3:0] valid_out = 4'h0,
  output logic [3:0] tick_out = 4'h0,
  output logic loc_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt [4];
  logic [1:0] lcnt = 2'h0;
  // Local frames every four cycles, free running
  always @(posedge clk) begin
    lcnt <= lcnt + 2'h1;
    loc_out <= (lcnt == 2'h3);
  end
  // A silent source sends no frames at all, not a stale pattern
  for (genvar i = 0; i < 4; i++) begin : g_src
    always @(posedge clk) begin
      valid_out[i] <= en_in[i];
      tick_out[i] <= en_in[i] && cnt[i] == 4'h0;
      if (!en_in[i] || cnt[i] >= per_in[4*i+:4] - 4'h1) begin
        cnt[i] <= 4'h0;
      end else begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
endmodule : acss_src_model
`default_nettype wire

//--- sim/tb_audio_clock_source_select.sv
`default_nettype none
// Self-checking bench for the clock source selector
module tb_audio_clock_source_select;
  timeunit 1ns;
  timeprecision 1ns;
  import acss_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] en = 4'h0;
  logic [15:0] per = 16'h4444;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire logic [3:0] rxv, rxt;
  wire logic loc, mst, irq, awr, wrdy, bv, arr, rv;
  wire logic [2:0] ref_o;
  wire logic [7:0] st;
  wire logic [1:0] spl, br, rr;
  wire logic [3:0] chn;
  wire logic [31:0] rdat;
  int fails = 0;
  int check_count = 0;
  logic [31:0] d;
  logic [1:0] r;

  // Short window keeps each settle short; two-window hysteresis is exercised
  acss_top #(.WIN_TICKS_P(8), .HYST_P(2)) dut (
    .CLOCK_IN(clk), .RESET_IN(rst), .RX_VALID_IN(rxv),
    .RX_FRAME_TICK_IN(rxt), .LOCAL_FRAME_TICK_IN(loc),
    .CLK_REF_OUT(ref_o), .CLOCK_MASTER_OUT(mst), .INPUT_STATE_OUT(st),
    .OPT_SPLIT_OUT(spl), .OPT_CHANNELS_OUT(chn), .IRQ_OUT(irq),
    .S_AXI_AWADDR_IN(awa), .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awr),
    .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv),
    .S_AXI_WREADY_OUT(wrdy), .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv),
    .S_AXI_BREADY_IN(bry), .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv),
    .S_AXI_ARREADY_OUT(arr), .S_AXI_RDATA_OUT(rdat), .S_AXI_RRESP_OUT(rr),
    .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rry));
  acss_src_model src_m (.clk(clk), .en_in(en), .per_in(per),
    .valid_out(rxv), .tick_out(rxt), .loc_out(loc));

  // Clock and watchdog; the limit is far above the expected run
  initial forever #50 clk = ~clk;
  initial begin
    #4000000;
    fails++;
    wrap_up();
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task wrap_up();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Each channel is released at the edge that takes it
  task wchk(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wrdy));
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
    chk(32'(br), 32'(e));
  endtask : wchk

  task rd(input logic [7:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rry <= 1'b0;
  endtask : rd

  task rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    rd(a);
    chk(d, e);
    chk(32'(r), 32'(re));
  endtask : rchk

  task ctrl(input logic [2:0] p, input logic [1:0] rt, input logic fx, s);
    wchk(OFS_CTRL, (32'(s) << CTRL_SINGLE_BIT) | (32'(rt) << CTRL_RATE_LSB)
      | (32'(p) << CTRL_PREF_LSB) | 32'(fx), 2'h0);
  endtask : ctrl

  task src(input logic [3:0] e, input logic [15:0] p);
    @(posedge clk);
    en <= e;
    per <= p;
  endtask : src

  task wait_sel(input logic [2:0] e, input logic m);
    int n;
    n = 0;
    while (n < 600 && (ref_o !== e || mst !== m)) begin
      @(posedge clk);
      n++;
    end
    chk({ref_o, mst}, {e, m});
  endtask : wait_sel

  task wait_st(input int i, input logic [1:0] e);
    int n;
    n = 0;
    while (n < 600 && st[2*i+:2] !== e) begin
      @(posedge clk);
      n++;
    end
    chk(32'(st[2*i+:2]), 32'(e));
  endtask : wait_st

  task t_reset();
    chk({ref_o, mst, st, spl, chn, irq}, {SRC_INTERNAL, 1'b1, 8'h00,
      SPLIT_NONE, CH_SINGLE, 1'b0});
    rchk(OFS_CTRL, CTRL_RESET, 2'h0);
    rchk(OFS_STATUS, 32'h0000_0800, 2'h0);
    rchk(OFS_IRQ_EN, 32'h0, 2'h0);
  endtask : t_reset

  task t_follow();
    ctrl(SRC_WORD, RATE_SINGLE, 1'b0, 1'b0);
    src(4'b0010, 16'h4444);
    wait_st(1, ST_SYNC);
    wait_sel(3'h2, 1'b0);
    rchk(OFS_STATUS, 32'h0000_0208, 2'h0);
  endtask : t_follow

  task t_pref();
    src(4'b0110, 16'h4444);
    ctrl(3'h3, RATE_SINGLE, 1'b0, 1'b0);
    wait_sel(3'h3, 1'b0);
    ctrl(3'h4, RATE_SINGLE, 1'b0, 1'b0);
    wait_sel(3'h2, 1'b0);
    src(4'b1110, 16'h6444);
    wait_st(3, ST_LOCK);
    wait_sel(3'h4, 1'b0);
  endtask : t_pref

  task t_loss();
    wchk(OFS_IRQ_CLR, 32'h7, 2'h0);
    wchk(OFS_IRQ_EN, 32'h1 << EVT_REF_LOST, 2'h0);
    src(4'b0000, 16'h4444);
    wait_sel(SRC_INTERNAL, 1'b1);
    wait_st(3, ST_ABSENT);
    rd(OFS_IRQ_STAT);
    chk(d, 32'h7);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wchk(OFS_IRQ_EN, 32'h0, 2'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wchk(OFS_IRQ_EN, 32'h2, 2'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    wchk(OFS_IRQ_CLR, 32'h2, 2'h0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    rchk(OFS_IRQ_EN, 32'h2, 2'h0);
    rchk(OFS_IRQ_CLR, 32'h0, 2'h2);
    rchk(8'h14, 32'h0, 2'h2);
    wchk(8'h20, 32'h1, 2'h2);
  endtask : t_loss

  task t_fixed();
    ctrl(3'h2, RATE_SINGLE, 1'b1, 1'b0);
    src(4'b0010, 16'h4444);
    wait_st(1, ST_SYNC);
    repeat (100) @(posedge clk);
    chk({ref_o, mst}, {SRC_INTERNAL, 1'b1});
    ctrl(3'h2, RATE_SINGLE, 1'b0, 1'b0);
    wait_sel(3'h2, 1'b0);
  endtask : t_fixed

  task t_rate();
    logic [5:0] tbl [4];
    tbl = '{{SPLIT_NONE, CH_SINGLE}, {SPLIT_TWO, CH_DOUBLE},
      {SPLIT_FOUR, CH_QUAD}, {SPLIT_FOUR, CH_QUAD}};
    for (int i = 0; i < 4; i++) begin
      ctrl(3'h2, 2'(i), 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      chk(32'({spl, chn}), 32'(tbl[i]));
    end
  endtask : t_rate

  task t_single();
    src(4'b0001, 16'h4448);
    ctrl(SRC_WORD, RATE_DOUBLE, 1'b0, 1'b1);
    wait_st(0, ST_SYNC);
    wait_sel(SRC_WORD, 1'b0);
  endtask : t_single

  // Word clock drops for exactly one window; lock must ride it out
  task t_hyst();
    int seen;
    seen = 0;
    src(4'b0000, 16'h4448);
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      if (k == 31) en <= 4'b0001;
      if (st[1:0] === ST_ABSENT || mst !== 1'b0) seen++;
    end
    chk(32'(seen), 32'h0);
    wait_sel(SRC_WORD, 1'b0);
  endtask : t_hyst

  // Second reset in mid-run, after the block has been busy
  task t_rerun();
    src(4'h0, 16'h4444);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
  endtask : t_rerun

  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_follow();
    t_pref();
    t_loss();
    t_fixed();
    t_rate();
    t_single();
    t_hyst();
    t_rerun();
    wrap_up();
  end
endmodule : tb_audio_clock_source_select
`default_nettype wire
